// ===== rtl/system_clock_source_select.v
// System clock source selection, prescaler and loop model, as tick stream
// The on-chip oscillator is i_clock itself; every derived clock is a one-cycle
// enable pulse on o_system_tick, so no derived rate can exceed i_clock.
// A source whose pin stops holds the adopted setting until it ticks again,
// since a switch is only made at the end of a whole system clock period.
`timescale 1ns/100ps
`default_nettype none

`include "clock_select_consts.vh"

module system_clock_source_select
(
	// Clock, reset and configuration fields
	input  wire                   i_clock,
	input  wire                   i_resetn,
	input  wire [1:0]             i_clock_source_select,
	input  wire                   i_oscillator_bypass,
	input  wire [`PRESCALE_W-1:0] i_prescaler_divide_field,
	input  wire [`INDIV_W-1:0]    i_input_divide_field,
	input  wire [`MULT_W-1:0]     i_feedback_multiply_field,
	input  wire [`OUTDIV_W-1:0]   i_output_divide_field,
	input  wire                   i_loop_reference_pin,
	input  wire [1:0]             i_oscillator_band_select,
	input  wire                   i_external_clock_pin,
	input  wire                   i_wakeup_clock_pin,
	// Derived tick and status
	output wire                   o_system_tick,
	output wire [1:0]             o_active_select,
	output wire                   o_loop_enable,
	output wire                   o_loop_locked,
	output wire                   o_config_pending,
	output wire [1:0]             o_oscillator_band_select
);

	// Adopted configuration, changed only at a safe point; band select is taken at once
	reg [1:0]             select_reg;
	reg                   bypass_reg;
	reg [`PRESCALE_W-1:0] prescale_reg;
	reg [`INDIV_W-1:0]    indiv_reg;
	reg [`MULT_W-1:0]     mult_reg;
	reg [`OUTDIV_W-1:0]   outdiv_reg;
	reg                   refpin_reg;
	reg                   first_reg;
	reg                   loop_en_reg;
	reg [1:0]             band_reg;

	// Loop model state
	reg [`MULT_W-1:0]     mult_now_reg;
	reg [`PEND_W-1:0]     pend_reg;
	reg [`PEND_W-1:0]     pend_next;
	reg                   locked_reg;

	// Tick streams and configuration strobes
	wire [1:0]            pin_rise;
	wire                  wakeup_tick;
	wire                  external_tick;
	wire                  prescale_tick;
	wire                  ref_tick;
	wire                  compare_tick;
	wire                  vco_tick;
	wire                  loop_tick;
	wire                  change;
	wire                  adopt;
	reg                   sys_tick;

	// Both clock pins are foreign to i_clock and pass two flip-flops
	// Only rising edges carry clock information; the levels are left open
	pin_edge_sync
	#(
		.WIDTH (2)
	)
	u_pins
	(
		.i_clock  (i_clock),
		.i_resetn (i_resetn),
		.i_pin    ({i_external_clock_pin, i_wakeup_clock_pin}),
		.o_level  (),
		.o_rise   (pin_rise)
	);

	assign wakeup_tick   = pin_rise[0];
	assign external_tick = pin_rise[1];

	// Any field differing from the adopted set is a pending change
	// Band select stays out of it, since the band never restarts a divider
	// Combinational, so pending shows in the cycle a field moves
	assign change = (i_clock_source_select != select_reg)
		| (i_oscillator_bypass != bypass_reg)
		| (i_prescaler_divide_field != prescale_reg)
		| (i_input_divide_field != indiv_reg)
		| (i_feedback_multiply_field != mult_reg)
		| (i_output_divide_field != outdiv_reg)
		| (i_loop_reference_pin != refpin_reg);

	// Switch at boundary
	// A change is taken only at the end of a system clock period, so the old
	// period completes and the prescaler or loop starts a whole one. A dead pin on the
	// active source holds the old setting until it ticks again.
	// Select 01 makes no ticks, so a change away from it is taken at once
	// rather than waiting for a tick that never comes.
	assign adopt = change & (first_reg | sys_tick | (select_reg == `SEL_RESERVED));

	// Latch configuration at the safe point
	always @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			select_reg   <= `RST_SELECT;
			bypass_reg   <= `RST_BYPASS;
			prescale_reg <= `RST_PRESCALE;
			indiv_reg    <= `RST_INDIV;
			mult_reg     <= `RST_MULT;
			outdiv_reg   <= `RST_OUTDIV;
			refpin_reg   <= 1'b0;
			first_reg    <= 1'b1;
			loop_en_reg  <= 1'b0;
		end
		else
		begin
			// The first cycle after reset adopts without waiting for a tick
			first_reg <= 1'b0;
			if (adopt)
			begin
				select_reg   <= i_clock_source_select;
				bypass_reg   <= i_oscillator_bypass;
				prescale_reg <= i_prescaler_divide_field;
				indiv_reg    <= i_input_divide_field;
				mult_reg     <= i_feedback_multiply_field;
				outdiv_reg   <= i_output_divide_field;
				refpin_reg   <= i_loop_reference_pin;
				loop_en_reg  <= (i_clock_source_select == `SEL_LOOP)
					& ~i_oscillator_bypass;
			end
		end
	end

	// Band select codes
	// Only the two defined codes are taken; others leave the band unchanged
	// The band only labels the loop oscillator range and never alters ticks,
	// so it is taken at once with no safe-point wait
	always @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			band_reg <= `RST_BAND;
		else if ((i_oscillator_band_select == `BAND_LOW) |
			(i_oscillator_band_select == `BAND_HIGH))
			band_reg <= i_oscillator_band_select;
	end

	// Ten-bit factor to 1024
	// Counts every cycle; restarted on adoption so the first period is whole
	tick_divider
	#(
		.WIDTH (`PRESCALE_W)
	)
	u_prescaler
	(
		.i_clock        (i_clock),
		.i_resetn       (i_resetn),
		.i_restart      (adopt),
		.i_tick         (1'b1),
		.i_divide_field (prescale_reg),
		.o_tick         (prescale_tick)
	);

	// On-chip reference choice
	// Reference is every oscillator cycle, or the synchronised external pin
	// A synchronised pin gives at most one edge every two cycles
	assign ref_tick = refpin_reg ? external_tick : 1'b1;

	// Held in restart while the loop is off, so it starts aligned on enable
	// Input divider P
	tick_divider
	#(
		.WIDTH (`INDIV_W)
	)
	u_input_divider
	(
		.i_clock        (i_clock),
		.i_resetn       (i_resetn),
		.i_restart      (adopt | ~loop_en_reg),
		.i_tick         (ref_tick),
		.i_divide_field (indiv_reg),
		.o_tick         (compare_tick)
	);

	// Multiplier N as pulse credit
	// Each compare tick grants N oscillator pulses, released one per cycle;
	// the rate is capped at i_clock, a limit of this single-clock model.
	// Credit saturates at the pending maximum rather than wrapping round.
	always @*
	begin
		pend_next = pend_reg;
		if (compare_tick)
		begin
			if ({1'b0, pend_reg} + {2'h0, mult_now_reg} >= {1'b0, `PEND_MAX})
				pend_next = `PEND_MAX;
			else
				pend_next = pend_reg + {1'b0, mult_now_reg} + 8'h01;
		end
		// A pulse spent this cycle leaves the credit
		if (vco_tick)
			pend_next = pend_next - 8'h01;
	end

	// One loop oscillator pulse per cycle while credit remains
	assign vco_tick = loop_en_reg & (pend_reg != 8'h00);

	// Gradual multiplier slew
	// Starts at N of one and moves one step per compare tick toward the target
	// Lock shows one cycle after the current multiplier meets the target; a new
	// target is a new adoption, which drops lock and slews again from one
	always @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			mult_now_reg <= `RST_MULT;
			pend_reg     <= 8'h00;
			locked_reg   <= 1'b0;
		end
		else if (adopt | ~loop_en_reg)
		begin
			mult_now_reg <= `RST_MULT;
			pend_reg     <= 8'h00;
			locked_reg   <= 1'b0;
		end
		else
		begin
			pend_reg <= pend_next;
			// Step only on a compare tick, one unit at a time
			if (compare_tick)
			begin
				if (mult_now_reg < mult_reg)
					mult_now_reg <= mult_now_reg + 7'h01;
				else if (mult_now_reg > mult_reg)
					mult_now_reg <= mult_now_reg - 7'h01;
			end
			locked_reg <= (mult_now_reg == mult_reg);
		end
	end

	// Restarted with the input divider so loop ticks begin a whole period
	// Output divider K2
	tick_divider
	#(
		.WIDTH (`OUTDIV_W)
	)
	u_output_divider
	(
		.i_clock        (i_clock),
		.i_resetn       (i_resetn),
		.i_restart      (adopt | ~loop_en_reg),
		.i_tick         (vco_tick),
		.i_divide_field (outdiv_reg),
		.o_tick         (loop_tick)
	);

	// Source multiplexer
	// Registered ticks meet here, so the system tick lands in the cycle a
	// source ticks; the reserved code gives no ticks at all
	always @*
	begin
		case (select_reg)
			`SEL_WAKEUP: sys_tick = wakeup_tick;
			`SEL_DIRECT: sys_tick = external_tick;
			`SEL_LOOP:   sys_tick = bypass_reg ? prescale_tick : loop_tick;
			default:     sys_tick = 1'b0;
		endcase
	end

	// Port outputs; lock reads low whenever the loop is off
	assign o_system_tick            = sys_tick;
	assign o_active_select          = select_reg;
	assign o_loop_enable            = loop_en_reg;
	assign o_loop_locked            = locked_reg & loop_en_reg;
	assign o_config_pending         = change;
	assign o_oscillator_band_select = band_reg;

endmodule // system_clock_source_select

`default_nettype wire

// ===== rtl/clock_select_consts.vh
// Constants of the system clock source selection block
`ifndef CLOCK_SELECT_CONSTS_VH
`define CLOCK_SELECT_CONSTS_VH

// Clock source select codes
`define SEL_WAKEUP          2'h0
`define SEL_RESERVED        2'h1
`define SEL_LOOP            2'h2
`define SEL_DIRECT          2'h3

// Oscillator band select codes
`define BAND_LOW            2'h0
`define BAND_HIGH           2'h1

// Field widths
`define PRESCALE_W          10
`define INDIV_W             4
`define MULT_W              7
`define OUTDIV_W            7
`define PEND_W              8

// Reset values of the adopted configuration
`define RST_SELECT          2'h0
`define RST_BYPASS          1'h1
`define RST_PRESCALE        10'h000
`define RST_INDIV           4'h0
`define RST_MULT            7'h00
`define RST_OUTDIV          7'h00
`define RST_BAND            2'h0

// Pending loop oscillator pulses saturate here
`define PEND_MAX            8'hFF

`endif

// ===== rtl/tick_divider.v
// Divides a stream of one-cycle ticks by a programmable field plus one
`timescale 1ns/100ps
`default_nettype none

module tick_divider
#(
	parameter WIDTH = 10
)
(
	input  wire             i_clock,
	input  wire             i_resetn,
	input  wire             i_restart,
	input  wire             i_tick,
	input  wire [WIDTH-1:0] i_divide_field,
	output wire             o_tick
);

	reg [WIDTH-1:0] count_reg;
	reg             tick_reg;

	// Count input ticks; emit one tick per field+1 input ticks
	always @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			count_reg <= {WIDTH{1'b0}};
			tick_reg  <= 1'b0;
		end
		else if (i_restart)
		begin
			// Restart begins a full new period, never a short one
			count_reg <= {WIDTH{1'b0}};
			tick_reg  <= 1'b0;
		end
		else if (i_tick)
		begin
			if (count_reg == i_divide_field)
			begin
				count_reg <= {WIDTH{1'b0}};
				tick_reg  <= 1'b1;
			end
			else
			begin
				count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
				tick_reg  <= 1'b0;
			end
		end
		else
		begin
			tick_reg <= 1'b0;
		end
	end

	assign o_tick = tick_reg;

endmodule // tick_divider

`default_nettype wire

// ===== rtl/pin_edge_sync.v
// Two-stage synchronisers with rising-edge pulses for clock pins
`timescale 1ns/100ps
`default_nettype none

module pin_edge_sync
#(
	parameter WIDTH = 2
)
(
	input  wire             i_clock,
	input  wire             i_resetn,
	input  wire [WIDTH-1:0] i_pin,
	output wire [WIDTH-1:0] o_level,
	output wire [WIDTH-1:0] o_rise
);

	genvar g;

	generate
		for (g = 0; g < WIDTH; g = g + 1)
		begin : gen_pin
			reg meta_reg;
			reg sync_reg;
			reg last_reg;
			reg rise_reg;

			// First stage feeds only the second stage
			always @(posedge i_clock or negedge i_resetn)
			begin
				if (!i_resetn)
				begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
					last_reg <= 1'b0;
					rise_reg <= 1'b0;
				end
				else
				begin
					meta_reg <= i_pin[g];
					sync_reg <= meta_reg;
					last_reg <= sync_reg;
					rise_reg <= sync_reg & ~last_reg;
				end
			end

			assign o_level[g] = sync_reg;
			assign o_rise[g]  = rise_reg;
		end
	endgenerate

endmodule // pin_edge_sync

`default_nettype wire

// ===== rtl/_unused_guard.v
// Spare design file; it holds no logic, the block is complete without it

// ===== sim/clock_select_checker_properties.sv
// Concurrent checks on the clock source selection ports
`timescale 1ns/100ps
`default_nettype none
module clock_select_checker
(
	input wire logic       i_clock,
	input wire logic       i_resetn,
	input wire logic [9:0] i_prescaler_divide_field,
	input wire logic [6:0] i_output_divide_field,
	input wire logic [1:0] i_oscillator_band_select,
	input wire logic       i_external_clock_pin,
	input wire logic       i_wakeup_clock_pin,
	input wire logic       o_system_tick,
	input wire logic [1:0] o_active_select,
	input wire logic       o_loop_enable,
	input wire logic       o_config_pending,
	input wire logic [1:0] o_oscillator_band_select
);
	logic [2:0] up_reg;
	logic [9:0] gap_reg;
	logic       clean_reg;
	wire        pre_mode = o_active_select == 2'h2 && !o_loop_enable && !o_config_pending;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);
	// Age since reset, so pin synchronisers can settle, and cycles since the last tick
	always_ff @(posedge i_clock or negedge i_resetn)
		if (!i_resetn)
		begin
			up_reg    <= 3'h0;
			gap_reg   <= 10'h000;
			clean_reg <= 1'b0;
		end
		else
		begin
			up_reg    <= up_reg + {2'h0, up_reg != 3'h7};
			gap_reg   <= o_system_tick ? 10'h000 : gap_reg + 10'h001;
			clean_reg <= o_system_tick ? pre_mode : clean_reg && pre_mode;
		end
	a_prescale_gap:
	assert property (o_system_tick && clean_reg && pre_mode |-> gap_reg == i_prescaler_divide_field)
	else $error("prescaler tick spacing wrong");
	a_direct_pin_edge:
	assert property (o_system_tick && o_active_select == 2'h3 && up_reg == 3'h7
		|-> $past(i_external_clock_pin, 3) && !$past(i_external_clock_pin, 4))
	else $error("direct tick without pin edge");
	a_wakeup_pin_edge:
	assert property (o_system_tick && o_active_select == 2'h0 && up_reg == 3'h7
		|-> $past(i_wakeup_clock_pin, 3) && !$past(i_wakeup_clock_pin, 4))
	else $error("wakeup tick without pin edge");
	a_loop_only_sel:
	assert property (o_loop_enable |-> o_active_select == 2'h2)
	else $error("loop enabled outside select 10");
	a_band_follow:
	assert property (!i_oscillator_band_select[1]
		|=> o_oscillator_band_select == $past(i_oscillator_band_select))
	else $error("band code not taken");
	a_band_hold:
	assert property (i_oscillator_band_select[1] |=> $stable(o_oscillator_band_select))
	else $error("band moved on unused code");
	a_switch_on_tick:
	assert property ($changed(o_active_select) && up_reg == 3'h7
		|-> $past(o_system_tick) || $past(o_active_select) == 2'h1)
	else $error("source switched between ticks");
	a_loop_spacing:
	assert property (o_system_tick && o_loop_enable && !o_config_pending
		&& i_output_divide_field != 7'h00 |=> !o_system_tick)
	else $error("loop ticks closer than output divider");
endmodule // clock_select_checker
bind system_clock_source_select clock_select_checker i_clock_select_checker
(
	.i_clock, .i_resetn, .i_prescaler_divide_field, .i_output_divide_field,
	.i_oscillator_band_select, .i_external_clock_pin, .i_wakeup_clock_pin, .o_system_tick,
	.o_active_select, .o_loop_enable, .o_config_pending, .o_oscillator_band_select
);
`default_nettype wire

// ===== sim/pin_clock_model.sv
// Free-running clock source that drives one clock pin
`timescale 1ns/100ps
`default_nettype none
module pin_clock_model
(
	input  wire logic       i_clock,
	input  wire logic [7:0] i_half,
	output wire logic       o_pin
);
	logic [7:0] count_reg = 8'h00;
	logic       pin_reg = 1'b0;
	// Square wave; a zero half period parks the pin
	always @(posedge i_clock)
		if (i_half != 8'h00)
		begin
			count_reg <= count_reg + 8'h01;
			if (count_reg >= i_half - 8'h01)
			begin
				count_reg <= 8'h00;
				pin_reg   <= ~pin_reg;
			end
		end
	// One driver for the pin
	assign o_pin = pin_reg;
endmodule // pin_clock_model
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench of the system clock source selection block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic       i_clock = 1'b0;
	logic       i_resetn = 1'b0;
	logic [1:0] i_clock_source_select = 2'h0;
	logic       i_oscillator_bypass = 1'b1;
	logic [9:0] i_prescaler_divide_field = 10'h000;
	logic [3:0] i_input_divide_field = 4'h0;
	logic [6:0] i_feedback_multiply_field = 7'h00;
	logic [6:0] i_output_divide_field = 7'h00;
	logic       i_loop_reference_pin = 1'b0;
	logic [1:0] i_oscillator_band_select = 2'h0;
	logic [1:0] eband = 2'h0;
	logic [9:0] f;
	wire        i_external_clock_pin;
	wire        i_wakeup_clock_pin;
	wire        o_system_tick;
	wire  [1:0] o_active_select;
	wire        o_loop_enable;
	wire        o_loop_locked;
	wire        o_config_pending;
	wire  [1:0] o_oscillator_band_select;
	int         fail_count = 0;
	int         n_tests = 0;
	int         ticks = 0;
	int         i;
	int         j;
	int         p;
	int         d;
	int         w;
	pin_clock_model ext_src (.i_clock(i_clock), .i_half(8'h03), .o_pin(i_external_clock_pin));
	pin_clock_model wu_src (.i_clock(i_clock), .i_half(8'h05), .o_pin(i_wakeup_clock_pin));
	system_clock_source_select i_system_clock_source_select
	(
		.i_clock, .i_resetn, .i_clock_source_select, .i_oscillator_bypass,
		.i_prescaler_divide_field, .i_input_divide_field, .i_feedback_multiply_field,
		.i_output_divide_field, .i_loop_reference_pin, .i_oscillator_band_select,
		.i_external_clock_pin, .i_wakeup_clock_pin, .o_system_tick, .o_active_select,
		.o_loop_enable, .o_loop_locked, .o_config_pending, .o_oscillator_band_select
	);
	// Clock and tick counter
	always #12.5 i_clock = ~i_clock;
	always @(posedge i_clock)
		if (o_system_tick === 1'b1)
			ticks <= ticks + 1;
	// Ideal loop tick rate, capped at one oscillator pulse a cycle
	function automatic real loop_rate(input int pp, input int n, input int k2, input int per);
		real v;
		v = 1.0 * n / (pp * per);
		return (v > 1.0 ? 1.0 : v) / k2;
	endfunction
	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic close_out;
		if (fail_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Whole setup in one edge, so no half-written mix is ever adopted
	task automatic setup(input logic [1:0] s, input logic b, input logic [9:0] k,
			input logic [3:0] pi, input logic [6:0] n, input logic [6:0] k2, input logic r);
		@(posedge i_clock);
		i_clock_source_select <= s;
		i_oscillator_bypass <= b;
		i_prescaler_divide_field <= k;
		i_input_divide_field <= pi;
		i_feedback_multiply_field <= n;
		i_output_divide_field <= k2;
		i_loop_reference_pin <= r;
		@(negedge i_clock);
		for (w = 0; w < 3000 && o_config_pending !== 1'b0; w++)
			@(negedge i_clock);
		check("pending", o_config_pending, 1'b0);
	endtask
	// Count ticks over a window against the ideal rate
	task automatic rate(input int win, input real r);
		int t0;
		real e;
		repeat (20) @(posedge i_clock);
		t0 = ticks;
		repeat (win) @(posedge i_clock);
		e = win * r;
		check("rate", (ticks - t0 >= e - 2.0 - e / 16) && (ticks - t0 <= e + 2.0 + e / 16), 1'b1);
	endtask
	// Main sequence
	initial
	begin
		void'($urandom(29));
		repeat (6) @(posedge i_clock);
		check("select_reset", o_active_select, 2'h0);
		i_resetn <= 1'b1;
		for (i = 0; i < 12; i++)
		begin
			j = (i < 4) ? i : $urandom_range(3, 0);
			@(posedge i_clock);
			i_oscillator_band_select <= j[1:0];
			if (j < 2)
				eband = j[1:0];
			@(posedge i_clock);
			@(negedge i_clock);
			check("band", o_oscillator_band_select, eband);
		end
		rate(400, 0.1);
		setup(2'h3, 1'b1, 10'h000, 4'h0, 7'h00, 7'h00, 1'b0);
		check("select_direct", o_active_select, 2'h3);
		rate(600, 1.0 / 6);
		for (i = 0; i < 6; i++)
		begin
			f = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom_range(63, 1));
			setup(2'h2, 1'b1, f, 4'h0, 7'h00, 7'h00, 1'b0);
			check("loop_off", o_loop_enable, 1'b0);
			rate(8 * (f + 1), 1.0 / (f + 1));
		end
		// Loop targets stay in a narrow range and the loop slews N itself
		for (i = 0; i < 4; i++)
		begin
			j = $urandom_range(15, 2);
			p = $urandom_range(3, 0);
			d = $urandom_range(7, 1);
			setup(2'h2, 1'b0, 10'h000, 4'(p), 7'(j), 7'(d), i[0]);
			check("loop_on", o_loop_enable, 1'b1);
			check("unlocked", o_loop_locked, 1'b0);
			for (w = 0; w < 4000 && o_loop_locked !== 1'b1; w++)
				@(negedge i_clock);
			check("locked", o_loop_locked, 1'b1);
			rate(1200, loop_rate(p + 1, j + 1, d + 1, i[0] ? 6 : 1));
		end
		// Reserved select gives no ticks and lets the next change in at once
		setup(2'h1, 1'b1, 10'h000, 4'h0, 7'h00, 7'h00, 1'b0);
		check("select_reserved", o_active_select, 2'h1);
		check("loop_reserved", o_loop_enable, 1'b0);
		rate(200, 0.0);
		setup(2'h0, 1'b1, 10'h000, 4'h0, 7'h00, 7'h00, 1'b0);
		check("select_wakeup", o_active_select, 2'h0);
		close_out();
	end
	// Cut a hang short: the tests need about 20000 cycles, this waits three times that
	initial
	begin
		repeat (60000) @(posedge i_clock);
		fail_count++;
		close_out();
	end
endmodule // testbench
`default_nettype wire
